// *** lcu_core.sv ***
`timescale 1ns/1ps
`default_nettype none
module lcu_core
    import lcu_pkg::*;
#(
    parameter int CW = CNT_W,
    parameter int HD = HIST_D
) (
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire lcu_setup_type setup,
    input  wire logic          advance,
    input  wire lcu_query_type query,
    input  wire logic          branch_valid,
    input  wire logic          branch_pred,
    input  wire logic          ctl_move_valid,
    input  wire lcu_unit_type  ctl_move_unit,
    input  wire logic          event_enter,
    input  wire logic          event_return,
    input  wire lcu_ctx_type   ctx_restore,
    input  wire lcu_dbg_type   dbg_sel,
    output logic               query_ack,
    output logic               query_pred,
    output logic               query_refused,
    output logic               ctl_move_refused,
    output logic               branch_done,
    output logic               branch_taken,
    output logic               ctx_save_valid,
    output lcu_ctx_type        ctx_save,
    output logic    [CW-1:0]   dbg_rdata,
    output logic               skew_illegal
);
    logic [CW-1:0]     inner_trip_q;
    logic [CW-1:0]     outer_trip_q;
    logic [CW-1:0]     inner_pos_q;
    logic [CW-1:0]     outer_pos_q;
    logic [CW-1:0]     ticks_q;
    logic [SKEW_W-1:0] skew_q;
    logic [CW-1:0]     inner_next;
    logic [CW-1:0]     outer_next;
    logic              inner_wrap;
    logic              outer_wrap;
    logic [CW-1:0]     target;
    logic [HD-1:0]     inner_hist;
    logic [HD-1:0]     outer_hist;
    logic              adv_go;
    logic              query_ack_q;
    logic              query_pred_q;
    logic              query_refused_q;
    logic              ctl_move_refused_q;
    logic              branch_done_q;
    logic              branch_taken_q;
    logic              ctx_save_valid_q;
    lcu_ctx_type       ctx_save_q;
    logic [CW-1:0]     dbg_rdata_q;
    logic              skew_illegal_q;

    function automatic logic unit_ok(input lcu_unit_type u);
        unit_ok = (u == UNIT_S1) || (u == UNIT_L1) || (u == UNIT_M1);
    endfunction : unit_ok

    function automatic logic skew_legal(input logic [SKEW_W-1:0] s);
        skew_legal = ($signed(s) >= $signed(SKEW_MIN))
                  && ($signed(s) <= $signed(SKEW_MAX));
    endfunction : skew_legal

    // advance ignored in the same cycle as setup or restore
    assign adv_go = advance && !setup.valid && !event_return;

    // odometer step
    always_comb begin
        inner_next = inner_pos_q + {{(CW-1){1'b0}}, 1'b1};
        outer_next = outer_pos_q;
        inner_wrap = 1'b0;
        outer_wrap = 1'b0;
        if (inner_next == inner_trip_q) begin // see RQ5
            inner_next = '0;
            inner_wrap = 1'b1;
            outer_next = outer_pos_q + {{(CW-1){1'b0}}, 1'b1};
            if (outer_next == outer_trip_q) begin
                outer_next = '0;
                outer_wrap = 1'b1;
            end
        end
    end

    // trip counts, positions and tick count
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            inner_trip_q <= CNT_RST;
            outer_trip_q <= CNT_RST;
            inner_pos_q  <= CNT_RST;
            outer_pos_q  <= CNT_RST;
            ticks_q      <= CNT_RST;
        end else if (setup.valid) begin
            inner_trip_q <= setup.inner; // see RQ1
            outer_trip_q <= setup.outer; // see RQ1
            inner_pos_q  <= CNT_RST;
            outer_pos_q  <= CNT_RST;
            ticks_q      <= CNT_RST;
        end else if (event_return) begin
            inner_trip_q <= ctx_restore.inner; // see RQ18
            outer_trip_q <= ctx_restore.outer; // see RQ18
        end else if (adv_go) begin
            inner_pos_q <= inner_next; // see RQ5
            outer_pos_q <= outer_next; // see RQ5
            ticks_q     <= ticks_q + {{(CW-1){1'b0}}, 1'b1};
        end
    end

    // skew register, debug visible only
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            skew_q         <= SKEW_RST;
            skew_illegal_q <= 1'b0;
        end else if (setup.valid) begin
            skew_q         <= setup.skew; // see RQ19
            skew_illegal_q <= !skew_legal(setup.skew); // see RQ2
        end
    end

    // predicate histories
    lcu_hist #(.DEPTH(HD)) u_inner_hist (
        .clk      (clk),
        .rst_n    (rst_n),
        .load     (setup.valid),
        .load_val (INNER_HIST_INIT), // see RQ3 see RQ9
        .shift    (adv_go), // see RQ6
        .new_bit  (inner_wrap),
        .hist     (inner_hist)
    );

    lcu_hist #(.DEPTH(HD)) u_outer_hist (
        .clk      (clk),
        .rst_n    (rst_n),
        .load     (setup.valid),
        .load_val (OUTER_HIST_INIT), // see RQ4
        .shift    (adv_go), // see RQ6
        .new_bit  (outer_wrap),
        .hist     (outer_hist)
    );

    // query answers from the state before any same-cycle advance
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            query_ack_q     <= 1'b0;
            query_pred_q    <= 1'b0;
            query_refused_q <= 1'b0;
        end else begin
            query_ack_q     <= query.valid && unit_ok(query.unit); // see RQ11
            query_refused_q <= query.valid && !unit_ok(query.unit);
            if (query.valid && unit_ok(query.unit)) begin
                query_pred_q <= query.level ? outer_hist[query.offset] // see RQ10
                                            : inner_hist[query.offset]; // see RQ8
            end
        end
    end

    // control move never reaches the loop registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctl_move_refused_q <= 1'b0;
        end else begin
            ctl_move_refused_q <= ctl_move_valid; // see RQ17
        end
    end

    // branch decision
    assign target = CW'(outer_trip_q * inner_trip_q)
                  + {{(CW-SKEW_W){skew_q[SKEW_W-1]}}, skew_q}; // see RQ12

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            branch_done_q  <= 1'b0;
            branch_taken_q <= 1'b0;
        end else begin
            branch_done_q  <= branch_valid;
            branch_taken_q <= branch_valid && branch_pred // see RQ15
                           && (ticks_q < target); // see RQ13
        end
    end

    // context save on event entry
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctx_save_valid_q <= 1'b0;
            ctx_save_q       <= '0;
        end else begin
            ctx_save_valid_q <= event_enter;
            if (event_enter) begin
                ctx_save_q.inner <= inner_trip_q; // see RQ18
                ctx_save_q.outer <= outer_trip_q; // see RQ18
            end
        end
    end

    // debug read path
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dbg_rdata_q <= '0;
        end else begin
            case (dbg_sel)
                DBG_INNER: begin
                    dbg_rdata_q <= inner_trip_q; // see RQ17
                end
                DBG_OUTER: begin
                    dbg_rdata_q <= outer_trip_q; // see RQ17
                end
                DBG_SKEW: begin
                    dbg_rdata_q <= {{(CW-SKEW_W){1'b0}}, skew_q}; // see RQ19
                end
                DBG_IHIST: begin
                    dbg_rdata_q <= {{(CW-HD){1'b0}}, inner_hist}; // see RQ20
                end
                DBG_OHIST: begin
                    dbg_rdata_q <= {{(CW-HD){1'b0}}, outer_hist}; // see RQ20
                end
                DBG_TICKS: begin
                    dbg_rdata_q <= ticks_q;
                end
                default: begin
                    dbg_rdata_q <= '0;
                end
            endcase
        end
    end

    assign query_ack        = query_ack_q;
    assign query_pred       = query_pred_q;
    assign query_refused    = query_refused_q;
    assign ctl_move_refused = ctl_move_refused_q;
    assign branch_done      = branch_done_q;
    assign branch_taken     = branch_taken_q;
    assign ctx_save_valid   = ctx_save_valid_q;
    assign ctx_save         = ctx_save_q;
    assign dbg_rdata        = dbg_rdata_q;
    assign skew_illegal     = skew_illegal_q;

    // checks
    property p_setup_load;
        @(posedge clk) disable iff (!rst_n)
        setup.valid |=> (inner_trip_q == $past(setup.inner))
            && (outer_trip_q == $past(setup.outer)) && (skew_q == $past(setup.skew));
    endproperty
    a_setup_load: assert property (p_setup_load) else $error("setup load wrong"); // see RQ1

    property p_inner_init;
        @(posedge clk) disable iff (!rst_n)
        setup.valid |=> (inner_hist == INNER_HIST_INIT);
    endproperty
    a_inner_init: assert property (p_inner_init) else $error("inner history init wrong"); // see RQ3

    property p_outer_init;
        @(posedge clk) disable iff (!rst_n)
        setup.valid |=> (outer_hist == OUTER_HIST_INIT);
    endproperty
    a_outer_init: assert property (p_outer_init) else $error("outer history init wrong"); // see RQ4

    property p_odometer;
        @(posedge clk) disable iff (!rst_n)
        (adv_go && (inner_pos_q + 64'h1 == inner_trip_q))
            |=> (inner_pos_q == 64'h0) && (inner_hist[0] == 1'b1);
    endproperty
    a_odometer: assert property (p_odometer) else $error("inner wrap missed"); // see RQ5

    property p_first_query;
        @(posedge clk) disable iff (!rst_n)
        (setup.valid ##1 (!adv_go && !setup.valid) ##1 (query.valid && unit_ok(query.unit) && !query.level
            && query.offset == 4'h0)) |=> (query_ack && query_pred);
    endproperty
    a_first_query: assert property (p_first_query) else $error("first query not true"); // see RQ9

    property p_unit;
        @(posedge clk) disable iff (!rst_n)
        (query.valid && query.unit == UNIT_OT) |=> (query_refused && !query_ack);
    endproperty
    a_unit: assert property (p_unit) else $error("query on wrong unit accepted"); // see RQ11

    property p_branch;
        @(posedge clk) disable iff (!rst_n)
        (branch_valid && branch_pred) |=> (branch_taken == ($past(ticks_q) < $past(target)));
    endproperty
    a_branch: assert property (p_branch) else $error("branch decision wrong"); // see RQ13

    property p_branch_pred;
        @(posedge clk) disable iff (!rst_n)
        (branch_valid && !branch_pred) |=> (branch_done && !branch_taken);
    endproperty
    a_branch_pred: assert property (p_branch_pred) else $error("suppressed branch taken"); // see RQ15

    property p_ctx;
        @(posedge clk) disable iff (!rst_n)
        event_enter |=> ctx_save_valid && (ctx_save.inner == $past(inner_trip_q));
    endproperty
    a_ctx: assert property (p_ctx) else $error("context save wrong"); // see RQ18

    property p_ctx_outer;
        @(posedge clk) disable iff (!rst_n)
        event_enter |=> ctx_save_valid && (ctx_save.outer == $past(outer_trip_q));
    endproperty
    a_ctx_outer: assert property (p_ctx_outer) else $error("outer context save wrong"); // see RQ18

    property p_restore;
        @(posedge clk) disable iff (!rst_n)
        (event_return && !setup.valid) |=> (inner_trip_q == $past(ctx_restore.inner))
            && (outer_trip_q == $past(ctx_restore.outer));
    endproperty
    a_restore: assert property (p_restore) else $error("context restore wrong"); // see RQ18

    property p_ctl_move;
        @(posedge clk) disable iff (!rst_n)
        ctl_move_valid |=> ctl_move_refused;
    endproperty
    a_ctl_move: assert property (p_ctl_move) else $error("control move not refused"); // see RQ17

    property p_skew_flag;
        @(posedge clk) disable iff (!rst_n)
        setup.valid |=> (skew_illegal == (($past(setup.skew) > SKEW_MAX) && ($past(setup.skew) != SKEW_MIN)));
    endproperty
    a_skew_flag: assert property (p_skew_flag) else $error("skew range flag wrong"); // see RQ2

    property p_ticks;
        @(posedge clk) disable iff (!rst_n)
        adv_go |=> (ticks_q == $past(ticks_q) + {{(CW-1){1'b0}}, 1'b1});
    endproperty
    a_ticks: assert property (p_ticks) else $error("advance count wrong"); // see RQ5

    property p_query_ack;
        @(posedge clk) disable iff (!rst_n)
        (query.valid && unit_ok(query.unit)) |=> (query_ack && !query_refused);
    endproperty
    a_query_ack: assert property (p_query_ack) else $error("query on legal unit refused"); // see RQ11

    property p_query_pred;
        @(posedge clk) disable iff (!rst_n)
        (query.valid && unit_ok(query.unit))
            |=> (query_pred == $past(query.level ? outer_hist[query.offset] : inner_hist[query.offset]));
    endproperty
    a_query_pred: assert property (p_query_pred) else $error("query predicate wrong"); // see RQ10

    property p_dbg_skew;
        @(posedge clk) disable iff (!rst_n)
        (dbg_sel == DBG_SKEW) |=> (dbg_rdata == {{(CW-SKEW_W){1'b0}}, $past(skew_q)});
    endproperty
    a_dbg_skew: assert property (p_dbg_skew) else $error("skew debug read wrong"); // see RQ19
endmodule : lcu_core
`default_nettype wire

// *** lcu_cpu_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module lcu_cpu_model
    import lcu_pkg::*;
(
    input  wire logic          clk,
    output var  lcu_setup_type setup,
    output var  logic          advance,
    output var  lcu_query_type query,
    output var  logic          branch_valid,
    output var  logic          branch_pred,
    output var  logic          ctl_move_valid,
    output var  lcu_unit_type  ctl_move_unit,
    output var  logic          event_enter,
    output var  logic          event_return,
    output var  lcu_ctx_type   ctx_restore,
    output var  lcu_dbg_type   dbg_sel
);
    initial begin
        setup = '0;
        advance = 1'b0;
        query = '0;
        branch_valid = 1'b0;
        branch_pred = 1'b0;
        ctl_move_valid = 1'b0;
        ctl_move_unit = UNIT_S1;
        event_enter = 1'b0;
        event_return = 1'b0;
        ctx_restore = '0;
        dbg_sel = DBG_INNER;
    end

    // counts are plain N, never zero, fixed before the nest starts
    // skew in -1..30 unless skew_illegal is wanted
    task automatic loop_setup(input logic [63:0] i, input logic [63:0] o, input logic [5:0] s);
        @(negedge clk);
        setup = {1'b1, i, o, s};
        @(negedge clk);
        setup = {1'b0, ~i, ~o, ~s};
    endtask : loop_setup

    // advance goes first in each loop body
    task automatic tick;
        @(negedge clk);
        advance = 1'b1;
        @(negedge clk);
        advance = 1'b0;
    endtask : tick

    task automatic ask(input lcu_unit_type u, input logic l, input logic [3:0] ofs, input logic adv);
        @(negedge clk);
        query = {1'b1, u, l, ofs};
        advance = adv;
        @(negedge clk);
        query = {1'b0, u, ~l, ~ofs};
        advance = 1'b0;
    endtask : ask

    task automatic branch(input logic p);
        @(negedge clk);
        branch_valid = 1'b1;
        branch_pred = p;
        @(negedge clk);
        branch_valid = 1'b0;
        branch_pred = ~p;
    endtask : branch

    task automatic ctl_move(input lcu_unit_type u);
        @(negedge clk);
        ctl_move_valid = 1'b1;
        ctl_move_unit = u;
        @(negedge clk);
        ctl_move_valid = 1'b0;
    endtask : ctl_move

    task automatic enter_event;
        @(negedge clk);
        event_enter = 1'b1;
        @(negedge clk);
        event_enter = 1'b0;
    endtask : enter_event

    task automatic leave_event(input lcu_ctx_type c);
        @(negedge clk);
        event_return = 1'b1;
        ctx_restore = c;
        @(negedge clk);
        event_return = 1'b0;
        ctx_restore = ~c;
    endtask : leave_event

    task automatic look(input lcu_dbg_type s);
        @(negedge clk);
        dbg_sel = s;
        @(negedge clk);
    endtask : look
endmodule : lcu_cpu_model
`default_nettype wire

// *** lcu_hist.sv ***
`timescale 1ns/1ps
`default_nettype none
module lcu_hist
    import lcu_pkg::*;
#(
    parameter int DEPTH = HIST_D
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             load,
    input  wire logic [DEPTH-1:0] load_val,
    input  wire logic             shift,
    input  wire logic             new_bit,
    output logic      [DEPTH-1:0] hist
);
    logic [DEPTH-1:0] hist_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hist_q <= '0;
        end else if (load) begin
            hist_q <= load_val;
        end else if (shift) begin
            hist_q <= {hist_q[DEPTH-2:0], new_bit}; // see RQ7
        end
    end

    assign hist = hist_q;

    property p_shift;
        @(posedge clk) disable iff (!rst_n)
        (shift && !load) |=> (hist_q[DEPTH-1:1] == $past(hist_q[DEPTH-2:0]))
            && (hist_q[0] == $past(new_bit));
    endproperty
    a_shift: assert property (p_shift) else $error("history did not shift"); // see RQ7
endmodule : lcu_hist
`default_nettype wire

// *** lcu_pkg.sv ***
// How it works
// RQ1: setup loads inner and outer trip counts and a 6-bit skew.
// RQ2: skew is signed, legal from minus one to thirty.
// RQ3: setup sets inner history to only bit zero high.
// RQ4: setup clears outer history.
// RQ5: advance steps counters odometer style, inner wrap bumps outer.
// RQ6: advance also updates both predicate histories.
// RQ7: histories shift upward, new predicate enters index zero.
// RQ8: query before advance sees preloop, after advance sees postloop.
// RQ9: query after setup, before first advance, returns true.
// RQ10: query takes level and constant offset selecting advances back.
// RQ11: query accepted on three units; control move on one only. The code refuses every control move, whatever its unit.
// RQ12: branch target is outer trip times inner trip plus skew.
// RQ13: branch taken while advances counted are below the target.
// RQ14: software loads trip counts with N, not N minus one.
// RQ15: branch is predicated; false predicate suppresses it.
// RQ16: software puts advance first in the pipelined loop body.
// RQ17: 64-bit trip counters readable by debug only, not control move.
// RQ18: event entry saves trip counters; return restores them.
// RQ19: skew held in a 6-bit debug-only register used by branch.
// RQ20: each history is sixteen bits indexed by the query offset.
// RQ21: software never starts a trip counter at zero.
// RQ22: software uses perfect nests with fixed, scaled counts.
package lcu_pkg;
    localparam int CNT_W  = 64;
    localparam int SKEW_W = 6;
    localparam int HIST_D = 16;
    localparam int OFS_W  = 4;

    localparam logic [HIST_D-1:0] INNER_HIST_INIT = 16'h0001;
    localparam logic [HIST_D-1:0] OUTER_HIST_INIT = 16'h0000;
    localparam logic [CNT_W-1:0]  CNT_RST         = 64'h0;
    localparam logic [SKEW_W-1:0] SKEW_RST        = 6'h00;
    localparam logic [SKEW_W-1:0] SKEW_MIN        = 6'h3f;
    localparam logic [SKEW_W-1:0] SKEW_MAX        = 6'h1e;

    typedef enum logic [1:0] {
        UNIT_S1 = 2'h0,
        UNIT_L1 = 2'h1,
        UNIT_M1 = 2'h2,
        UNIT_OT = 2'h3
    } lcu_unit_type;

    typedef enum logic [2:0] {
        DBG_INNER = 3'h0,
        DBG_OUTER = 3'h1,
        DBG_SKEW  = 3'h2,
        DBG_IHIST = 3'h3,
        DBG_OHIST = 3'h4,
        DBG_TICKS = 3'h5
    } lcu_dbg_type;

    typedef struct packed {
        logic              valid;
        logic [CNT_W-1:0]  inner;
        logic [CNT_W-1:0]  outer;
        logic [SKEW_W-1:0] skew;
    } lcu_setup_type;

    typedef struct packed {
        logic               valid;
        lcu_unit_type       unit;
        logic               level;
        logic [OFS_W-1:0]   offset;
    } lcu_query_type;

    typedef struct packed {
        logic [CNT_W-1:0] inner;
        logic [CNT_W-1:0] outer;
    } lcu_ctx_type;
endpackage : lcu_pkg

// *** lcu_testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(act, exp) begin check_count++; if ((act) !== (exp)) begin n_fail++; $display("BAD t=%0t got=%h exp=%h", $time, (act), (exp)); end end
module testbench;
    import lcu_pkg::*;
    logic          clk;
    logic          rst_n;
    lcu_setup_type setup;
    logic          advance;
    lcu_query_type query;
    logic          branch_valid;
    logic          branch_pred;
    logic          ctl_move_valid;
    lcu_unit_type  ctl_move_unit;
    logic          event_enter;
    logic          event_return;
    lcu_ctx_type   ctx_restore;
    lcu_dbg_type   dbg_sel;
    logic          query_ack;
    logic          query_pred;
    logic          query_refused;
    logic          ctl_move_refused;
    logic          branch_done;
    logic          branch_taken;
    logic          ctx_save_valid;
    lcu_ctx_type   ctx_save;
    logic [63:0]   dbg_rdata;
    logic          skew_illegal;
    int            n_fail = 0;
    int            check_count = 0;
    int            cycles = 0;
    logic [63:0]   m_it, m_ot, m_ip, m_op, m_t;
    logic [5:0]    m_sk;
    logic [15:0]   m_ih, m_oh;

    lcu_cpu_model cpu (.clk(clk), .setup(setup), .advance(advance), .query(query),
        .branch_valid(branch_valid), .branch_pred(branch_pred), .ctl_move_valid(ctl_move_valid),
        .ctl_move_unit(ctl_move_unit), .event_enter(event_enter), .event_return(event_return),
        .ctx_restore(ctx_restore), .dbg_sel(dbg_sel));

    lcu_core uut (.clk(clk), .rst_n(rst_n), .setup(setup), .advance(advance), .query(query),
        .branch_valid(branch_valid), .branch_pred(branch_pred), .ctl_move_valid(ctl_move_valid),
        .ctl_move_unit(ctl_move_unit), .event_enter(event_enter), .event_return(event_return),
        .ctx_restore(ctx_restore), .dbg_sel(dbg_sel), .query_ack(query_ack), .query_pred(query_pred),
        .query_refused(query_refused), .ctl_move_refused(ctl_move_refused), .branch_done(branch_done),
        .branch_taken(branch_taken), .ctx_save_valid(ctx_save_valid), .ctx_save(ctx_save),
        .dbg_rdata(dbg_rdata), .skew_illegal(skew_illegal));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            summarize();
        end
    end

    task automatic peek(input lcu_dbg_type s, input logic [63:0] e);
        cpu.look(s);
        `CHK(dbg_rdata, e)
    endtask : peek

    task automatic ask(input lcu_unit_type u, input logic l, input logic [3:0] o, input logic a, input logic e);
        cpu.ask(u, l, o, a);
        `CHK(query_ack, 1'b1)
        `CHK(query_pred, e)
    endtask : ask

    task automatic br(input logic p);
        logic [63:0] tgt;
        tgt = m_ot * m_it + {{58{m_sk[5]}}, m_sk};
        cpu.branch(p);
        `CHK(branch_done, 1'b1)
        `CHK(branch_taken, p && (m_t < tgt))
    endtask : br

    task automatic do_setup(input logic [63:0] i, input logic [63:0] o, input logic [5:0] s);
        cpu.loop_setup(i, o, s);
        m_it = i;
        m_ot = o;
        m_sk = s;
        m_ip = '0;
        m_op = '0;
        m_t = '0;
        m_ih = 16'h0001;
        m_oh = 16'h0000;
    endtask : do_setup

    task automatic m_tick;
        logic iw;
        logic ow;
        m_t++;
        m_ip++;
        iw = (m_ip == m_it);
        ow = 1'b0;
        if (iw) begin
            m_ip = '0;
            m_op++;
            if (m_op == m_ot) begin
                m_op = '0;
                ow = 1'b1;
            end
        end
        m_ih = {m_ih[14:0], iw};
        m_oh = {m_oh[14:0], ow};
    endtask : m_tick

    task automatic t_setup;
        do_setup(64'h1, 64'h1, 6'h00);
        cpu.tick();
        cpu.tick();
        do_setup(64'hfedc_ba98_7654_3210, 64'h0123_4567_89ab_cdef, 6'h1e);
        peek(DBG_INNER, m_it);
        peek(DBG_OUTER, m_ot);
        peek(DBG_SKEW, 64'h1e);
        peek(DBG_IHIST, 64'h1);
        peek(DBG_OHIST, 64'h0);
        peek(DBG_TICKS, 64'h0);
    endtask : t_setup

    task automatic t_units;
        for (int u = 0; u < 4; u++) begin
            cpu.ask(lcu_unit_type'(u), 1'b0, 4'h0, 1'b0);
            `CHK(query_ack, (u < 3))
            `CHK(query_refused, (u == 3))
        end
        cpu.ctl_move(UNIT_S1);
        `CHK(ctl_move_refused, 1'b1)
    endtask : t_units

    task automatic t_run;
        do_setup(64'h3, 64'h2, 6'h01);
        ask(UNIT_S1, 1'b0, 4'h0, 1'b0, 1'b1);
        for (int k = 0; k < 8; k++) begin
            br(1'b1);
            ask(UNIT_S1, 1'b0, 4'h0, 1'b1, m_ih[0]);
            m_tick();
            ask(UNIT_L1, 1'b0, 4'(k), 1'b0, m_ih[k]);
            ask(UNIT_M1, 1'b1, 4'(k), 1'b0, m_oh[k]);
            peek(DBG_IHIST, {48'h0, m_ih});
            peek(DBG_OHIST, {48'h0, m_oh});
            peek(DBG_TICKS, m_t);
        end
        br(1'b1);
    endtask : t_run

    task automatic t_skew;
        do_setup(64'h1, 64'h2, 6'h3f);
        `CHK(skew_illegal, 1'b0)
        br(1'b0);
        br(1'b1);
        cpu.tick();
        m_tick();
        br(1'b1);
        peek(DBG_SKEW, 64'h3f);
        do_setup(64'h1, 64'h1, 6'h1f);
        `CHK(skew_illegal, 1'b1)
    endtask : t_skew

    task automatic t_event;
        do_setup(64'h5, 64'h9, 6'h00);
        cpu.tick();
        cpu.enter_event();
        `CHK(ctx_save_valid, 1'b1)
        `CHK(ctx_save.inner, 64'h5)
        `CHK(ctx_save.outer, 64'h9)
        cpu.leave_event({64'h77, 64'h88});
        peek(DBG_INNER, 64'h77);
        peek(DBG_OUTER, 64'h88);
        peek(DBG_TICKS, 64'h1);
    endtask : t_event

    initial begin
        rst_n = 1'b0;
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        t_setup();
        t_units();
        t_run();
        t_skew();
        t_event();
        summarize();
    end
endmodule : testbench
`default_nettype wire
